// [logic/dg_map.svh]
// address map, status bit positions and reset values of the data address unit
`ifndef DG_MAP_SVH
`define DG_MAP_SVH

// status bit positions
`define DG_BIT_WDOG    6
`define DG_BIT_PWDN    5
`define DG_BIT_N       4
`define DG_BIT_C       0
`define DG_ARITH_MSB   4
`define DG_STATUS_RST  8'h60
`define DG_STATUS_ADDR 12'hFD8

// pointer block layout, counted down from each block top
`define DG_PAIR0_TOP   12'hFEF
`define DG_PAIR_STRIDE 12'h008
`define DG_OFS_SPAN    12'h007
`define DG_OFS_IND     3'h0
`define DG_OFS_INC_AFT 3'h1
`define DG_OFS_DEC_AFT 3'h2
`define DG_OFS_INC_BEF 3'h3
`define DG_OFS_W_OFS   3'h4
`define DG_OFS_HI      3'h5
`define DG_OFS_LO      3'h6

// direct addressing
`define DG_ACC_SPLIT   8'h60
`define DG_ACC_HI_BANK 4'hF
`define DG_ACC_LO_BANK 4'h0
`define DG_IDX_LIMIT   8'h5F
`define DG_VOID_READ   8'h00
`define DG_PTR_ONE     12'h001

`endif

// [logic/dg_pkg.sv]
// types shared by the data address unit
package dg_pkg;
  typedef enum logic [3:0] {DG_NONE, DG_ADD, DG_SUB, DG_AND, DG_IOR, DG_XOR,
                            DG_RLC, DG_RRC, DG_MOV} dg_op_t;
  typedef enum logic [1:0] {DG_M_INH, DG_M_LIT, DG_M_DIR, DG_M_FULL} dg_mode_t;
  typedef enum logic [2:0] {DG_C_MEM, DG_C_STAT, DG_C_PTR, DG_C_VIRT, DG_C_VOID} dg_cls_t;
  typedef struct packed {
    dg_cls_t    cls;
    logic [1:0] pair;
    logic [2:0] sub;
  } dg_loc_t;
endpackage

// [logic/dg_alu.sv]
// byte alu with status flag generation
`timescale 1ns/10ps
`default_nettype none
module dg_alu
  import dg_pkg::*;
(
  // operation
  input  wire dg_pkg::dg_op_t op_i,
  input  wire logic [7:0]     a_i,
  input  wire logic [7:0]     b_i,
  input  wire logic           c_i,
  // result, flags {n,ov,z,dc,c} and their update mask
  output logic [7:0]          res_o,
  output logic [4:0]          flags_o,
  output logic [4:0]          mask_o
);
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [7:0] bx;
  logic       cin;
  logic       c;
  logic       hc;
  logic       ovf;

  always_comb
  begin
    cin    = (op_i == DG_SUB);
    // subtraction adds the two's complement, so carry reads as inverted borrow
    bx     = cin ? ~b_i : b_i;                                            // RULE7
    sum9   = {1'b0, a_i} + {1'b0, bx} + {8'h00, cin};
    half5  = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    res_o  = a_i;
    c      = c_i;
    hc     = 1'b0;
    ovf    = 1'b0;
    mask_o = 5'h00;
    unique case (op_i)
      DG_ADD, DG_SUB:
      begin
        res_o  = sum9[7:0];
        c      = sum9[8];                                                 // RULE7
        hc     = half5[4];                                                // RULE6
        ovf    = (a_i[7] == bx[7]) && (sum9[7] != a_i[7]);                // RULE4
        mask_o = 5'h1F;
      end
      DG_AND:
      begin
        res_o  = a_i & b_i;
        mask_o = 5'h14;
      end
      DG_IOR:
      begin
        res_o  = a_i | b_i;
        mask_o = 5'h14;
      end
      DG_XOR:
      begin
        res_o  = a_i ^ b_i;
        mask_o = 5'h14;
      end
      DG_RLC:
      begin
        res_o  = {a_i[6:0], c_i};
        c      = a_i[7];                                                  // RULE8
        mask_o = 5'h15;
      end
      DG_RRC:
      begin
        res_o  = {c_i, a_i[7:1]};
        c      = a_i[0];                                                  // RULE8
        mask_o = 5'h15;
      end
      DG_NONE, DG_MOV:
      begin
        res_o  = a_i;
      end
    endcase
    flags_o = {res_o[7], ovf, (res_o == 8'h00), hc, c};                   // RULE3 RULE5
  end
endmodule // dg_alu
`default_nettype wire

// [logic/dg_ptrs.sv]
// bank of pointer pairs with byte write and step by one
`timescale 1ns/10ps
`default_nettype none
module dg_ptrs #(
  parameter int PAIRS = 3,
  parameter int AW    = 12
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // byte write
  input  wire logic                      wr_i,
  input  wire logic [1:0]                wr_pair_i,
  input  wire logic                      wr_hi_i,
  input  wire logic [7:0]                wr_data_i,
  // step
  input  wire logic                      step_i,
  input  wire logic [1:0]                step_pair_i,
  input  wire logic                      step_dn_i,
  // pointers
  output logic [PAIRS-1:0][AW-1:0]       ptr_o
);
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ptr_o <= '0;
    else
      for (int n = 0; n < PAIRS; n++)
      begin
        // a write wins over a step in the same cycle; dg_core drops the step of a pair written through its own operand
        if (wr_i && wr_pair_i == 2'(n))                                   // RULE20
        begin
          if (wr_hi_i)
            ptr_o[n][AW-1:8] <= wr_data_i[AW-9:0];                        // RULE14
          else
            ptr_o[n][7:0] <= wr_data_i;
        end
        else if (step_i && step_pair_i == 2'(n))
          // full-width add: the low byte carries into the high byte
          ptr_o[n] <= step_dn_i ? ptr_o[n] - AW'(1) : ptr_o[n] + AW'(1);  // RULE18
      end
  end
endmodule // dg_ptrs
`default_nettype wire

// [logic/dg_core.sv]
// data address generation and status flags of the cpu core
// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// (RULE1) watchdog flag clears on time-out, sets on reset, watchdog clear or sleep
// (RULE2) powerdown flag sets on reset or watchdog clear, clears on sleep
// (RULE3) negative flag copies alu result bit seven
// (RULE4) overflow flag sets when signed result flips the sign bit
// (RULE5) zero flag sets when result is zero, else clears
// (RULE6) half carry is carry from bit three; inverted borrow on subtract
// (RULE7) carry is carry out of bit seven; subtract adds two's complement
// (RULE8) rotate through carry loads carry from the bit shifted out
// (RULE9) jump targets are 20-bit addresses taken from the opcode
// (RULE10) access select one joins bank select with the 8-bit address
// (RULE11) access select zero uses the access bank, bank select ignored
// (RULE12) full address move ignores bank select entirely
// (RULE13) destination bit one writes back to source, zero to accumulator
// (RULE14) three pointer pairs hold 12-bit addresses, high nibble unused
// (RULE15) plain indirect operand uses pointer unchanged, banking ignored
// (RULE16) post operands step pointer after access; pre-increment steps before
// (RULE17) accumulator offset operand adds signed accumulator, changes nothing
// (RULE18) pointer steps carry across the pair and leave flags alone
// (RULE19) indirect access to a virtual operand reads zero, write ignored
// (RULE20) write to a pair through its own operand is not stepped
// (RULE21) indexed literal offset only when the extended set option is one
// (RULE22) flag instruction aimed at status stores only its flags
// (RULE23) extended set, access zero, address up to 5Fh indexes third pair
// (RULE24) accumulator offset address wraps within 12 bits
`timescale 1ns/10ps
`default_nettype none
`include "dg_map.svh"
module dg_core #(
  parameter int PAIRS = 3,
  parameter int AW    = 12
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // instruction from decoder
  input  wire logic                   step_i,
  input  wire dg_pkg::dg_op_t         op_i,
  input  wire dg_pkg::dg_mode_t       mode_i,
  input  wire logic                   acc_sel_i,
  input  wire logic                   dest_sel_i,
  input  wire logic [7:0]             file_addr_i,
  input  wire logic [AW-1:0]          src_full_i,
  input  wire logic [AW-1:0]          dst_full_i,
  input  wire logic [7:0]             lit_i,
  input  wire logic [3:0]             bank_sel_i,
  input  wire logic [7:0]             wreg_i,
  input  wire logic                   ext_set_i,
  // control flow
  input  wire logic                   jump_i,
  input  wire logic [19:0]            jump_target_i,
  // core events
  input  wire logic                   wdt_timeout_i,
  input  wire logic                   wdt_clear_i,
  input  wire logic                   sleep_i,
  // data memory
  input  wire logic [7:0]             mem_rdata_i,
  output logic [AW-1:0]               mem_addr_o,
  output logic                        mem_rd_o,
  output logic                        mem_wr_o,
  output logic [7:0]                  mem_wdata_o,
  // results
  output logic                        busy_o,
  output logic                        wreg_we_o,
  output logic [7:0]                  wreg_data_o,
  output logic [7:0]                  status_o,
  output logic                        pc_load_o,
  output logic [19:0]                 pc_target_o,
  output logic [PAIRS-1:0][AW-1:0]    ptr_o
);
  import dg_pkg::*;

  typedef enum {S_IDLE, S_READ, S_EXEC} dg_state_t;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic dg_loc_t locate(input logic [AW-1:0] a);
    logic [AW-1:0] d;
    dg_loc_t       l;
    l = '{cls: DG_C_MEM, pair: 2'h0, sub: 3'h0};
    for (int n = 0; n < PAIRS; n++)
    begin
      d = `DG_PAIR0_TOP - AW'(n) * `DG_PAIR_STRIDE - a;
      if (d < `DG_OFS_SPAN)
      begin
        l.pair = 2'(n);
        l.sub  = d[2:0];
        l.cls  = (d[2:0] >= `DG_OFS_HI) ? DG_C_PTR : DG_C_VIRT;
      end
    end
    if (a == `DG_STATUS_ADDR)
      l.cls = DG_C_STAT;
    return l;
  endfunction

  function automatic logic [AW-1:0] direct_addr(input logic [7:0] f, input logic a_sel,
                                                input logic [3:0] bank, input logic ext,
                                                input logic [AW-1:0] p2);
    if (a_sel)
      return {bank, f};                                                   // RULE10
    else if (ext && f <= `DG_IDX_LIMIT)
      return p2 + {4'h0, f};                                              // RULE21 RULE23
    else if (f >= `DG_ACC_SPLIT)
      return {`DG_ACC_HI_BANK, f};                                        // RULE11
    else
      return {`DG_ACC_LO_BANK, f};                                        // RULE11
  endfunction

  // ****************************************************************
  // operand address for an accepted instruction
  // ****************************************************************
  dg_state_t       st;
  dg_state_t       next_st;
  dg_loc_t         l0;
  dg_loc_t         l1;
  dg_loc_t         ld;
  logic [AW-1:0]   base;
  logic [AW-1:0]   pv;
  logic [AW-1:0]   ea;
  logic [AW-1:0]   daddr;
  logic            accept;
  logic            full_mov;
  logic            upd;
  logic            upd_sup;
  logic            to_w;

  assign accept   = step_i && st == S_IDLE && mode_i != DG_M_INH;
  assign full_mov = mode_i == DG_M_FULL && op_i == DG_MOV;

  always_comb
  begin
    // full mode carries the whole address, so bank select is never read
    base = (mode_i == DG_M_FULL) ? src_full_i                            // RULE12
         : direct_addr(file_addr_i, acc_sel_i, bank_sel_i, ext_set_i, ptr_o[2]);
    l0   = locate(base);
    pv   = ptr_o[l0.pair];
    ea   = base;
    if (l0.cls == DG_C_VIRT)
    begin
      unique case (l0.sub)
        `DG_OFS_INC_BEF: ea = pv + `DG_PTR_ONE;                           // RULE16
        // signed offset, sum kept to the address width so it wraps
        `DG_OFS_W_OFS:  ea = pv + {{4{wreg_i[7]}}, wreg_i};               // RULE17 RULE24
        default:        ea = pv;                                          // RULE15
      endcase
    end
    l1 = (l0.cls == DG_C_VIRT) ? locate(ea) : l0;
    if (l0.cls == DG_C_VIRT && l1.cls == DG_C_VIRT)
      l1.cls = DG_C_VOID;                                                 // RULE19
    daddr = full_mov ? dst_full_i : ea;
    ld    = full_mov ? locate(dst_full_i) : l1;
    if (full_mov && ld.cls == DG_C_VIRT)
      ld.cls = DG_C_VOID;
    to_w    = mode_i == DG_M_LIT || (!dest_sel_i && !full_mov);           // RULE13
    upd_sup = !to_w && ld.cls == DG_C_PTR && ld.pair == l0.pair;          // RULE20
    upd     = accept && mode_i != DG_M_LIT && l0.cls == DG_C_VIRT && !upd_sup
              && (l0.sub == `DG_OFS_INC_AFT || l0.sub == `DG_OFS_DEC_AFT
                  || l0.sub == `DG_OFS_INC_BEF);                          // RULE16
  end

  // ****************************************************************
  // latched instruction
  // ****************************************************************
  dg_op_t        op_q;
  dg_loc_t       src_q;
  dg_loc_t       dst_q;
  logic [AW-1:0] dst_addr_q;
  logic [7:0]    lit_q;
  logic [7:0]    w_q;
  logic          lit_mode_q;
  logic          to_w_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      op_q       <= DG_NONE;
      src_q      <= '0;
      dst_q      <= '0;
      dst_addr_q <= '0;
      lit_q      <= 8'h00;
      w_q        <= 8'h00;
      lit_mode_q <= 1'b0;
      to_w_q     <= 1'b0;
    end
    else if (accept)
    begin
      op_q       <= op_i;
      src_q      <= l1;
      dst_q      <= ld;
      dst_addr_q <= daddr;
      lit_q      <= lit_i;
      w_q        <= wreg_i;
      lit_mode_q <= mode_i == DG_M_LIT;
      to_w_q     <= to_w;
    end
  end

  always_comb
  begin
    unique case (st)
      S_IDLE:  next_st = accept ? ((mode_i == DG_M_LIT) ? S_EXEC : S_READ) : S_IDLE;
      S_READ:  next_st = S_EXEC;
      S_EXEC:  next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st     <= S_IDLE;
      busy_o <= 1'b0;
    end
    else
    begin
      st     <= next_st;
      busy_o <= next_st != S_IDLE;
    end
  end

  // ****************************************************************
  // execute
  // ****************************************************************
  logic [7:0] opnd;
  logic [7:0] alu_res;
  logic [4:0] alu_flags;
  logic [4:0] alu_mask;
  logic       exec;
  logic       wr_dst;

  assign exec   = st == S_EXEC;
  assign wr_dst = exec && !to_w_q;

  always_comb
  begin
    opnd = `DG_VOID_READ;                                                 // RULE19
    if (lit_mode_q)
      opnd = lit_q;
    else
      unique case (src_q.cls)
        DG_C_MEM:  opnd = mem_rdata_i;
        DG_C_STAT: opnd = status_o;
        DG_C_PTR:  opnd = (src_q.sub == `DG_OFS_HI) ? {4'h0, ptr_o[src_q.pair][AW-1:8]}
                                                   : ptr_o[src_q.pair][7:0];
        default:   opnd = `DG_VOID_READ;
      endcase
  end

  dg_alu u_alu (
    .op_i    (op_q),
    .a_i     (opnd),
    .b_i     (w_q),
    .c_i     (status_o[`DG_BIT_C]),
    .res_o   (alu_res),
    .flags_o (alu_flags),
    .mask_o  (alu_mask)
  );

  dg_ptrs #(.PAIRS(PAIRS), .AW(AW)) u_ptrs (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wr_i        (wr_dst && dst_q.cls == DG_C_PTR),
    .wr_pair_i   (dst_q.pair),
    .wr_hi_i     (dst_q.sub == `DG_OFS_HI),
    .wr_data_i   (alu_res),
    .step_i      (upd),
    .step_pair_i (l0.pair),
    .step_dn_i   (l0.sub == `DG_OFS_DEC_AFT),
    .ptr_o       (ptr_o)
  );

  // memory strobes and accumulator write-back
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_addr_o  <= '0;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
      wreg_we_o   <= 1'b0;
      wreg_data_o <= 8'h00;
    end
    else
    begin
      mem_rd_o  <= accept && mode_i != DG_M_LIT && l1.cls == DG_C_MEM;
      mem_wr_o  <= wr_dst && dst_q.cls == DG_C_MEM;
      wreg_we_o <= exec && to_w_q;                                        // RULE13
      if (accept && mode_i != DG_M_LIT)
        mem_addr_o <= ea;
      else if (wr_dst)
        mem_addr_o <= dst_addr_q;                                         // RULE13
      if (wr_dst)
        mem_wdata_o <= alu_res;
      if (exec && to_w_q)
        wreg_data_o <= alu_res;
    end
  end

  // ****************************************************************
  // status register and control flow
  // ****************************************************************
  logic [4:0] next_arith;

  always_comb
  begin
    next_arith = status_o[`DG_ARITH_MSB:0];
    // a flag instruction aimed at status keeps only its flags
    if (wr_dst && dst_q.cls == DG_C_STAT && alu_mask == 5'h00)
      next_arith = alu_res[`DG_ARITH_MSB:0];                              // RULE22
    if (exec)
      next_arith = (next_arith & ~alu_mask) | (alu_flags & alu_mask);     // RULE3 RULE4 RULE5
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      status_o <= `DG_STATUS_RST;                                         // RULE1 RULE2
    else
    begin
      status_o[`DG_ARITH_MSB:0] <= next_arith;                            // RULE18
      if (wdt_timeout_i)
        status_o[`DG_BIT_WDOG] <= 1'b0;                                   // RULE1
      else if (wdt_clear_i || sleep_i)
        status_o[`DG_BIT_WDOG] <= 1'b1;                                   // RULE1
      if (wdt_clear_i)
        status_o[`DG_BIT_PWDN] <= 1'b1;                                   // RULE2
      else if (sleep_i)
        status_o[`DG_BIT_PWDN] <= 1'b0;                                   // RULE2
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_load_o   <= 1'b0;
      pc_target_o <= 20'h00000;
    end
    else
    begin
      pc_load_o <= jump_i;
      if (jump_i)
        pc_target_o <= jump_target_i;                                     // RULE9
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_void_issue;
    accept && mode_i == DG_M_DIR && l1.cls == DG_C_VOID;
  endsequence

  sequence s_no_access;
    !mem_rd_o ##1 !mem_rd_o ##1 !mem_wr_o;
  endsequence

  AST_WDOG_CLR: assert property (wdt_timeout_i |=> !status_o[`DG_BIT_WDOG]) // RULE1
    else $error("watchdog flag not cleared by time-out");
  AST_PWDN_SLEEP: assert property (sleep_i && !wdt_clear_i |=> !status_o[`DG_BIT_PWDN]) // RULE2
    else $error("powerdown flag not cleared by sleep");
  AST_NEG: assert property (exec && alu_mask[4] |=> status_o[4] == $past(alu_res[7])) // RULE3
    else $error("negative flag differs from result sign");
  AST_ZERO: assert property (exec && alu_mask[2]
                             |=> status_o[2] == ($past(alu_res) == 8'h00)) // RULE5
    else $error("zero flag wrong");
  AST_RLC_C: assert property (exec && op_q == DG_RLC |=> status_o[0] == $past(opnd[7])) // RULE8
    else $error("rotate left did not load carry from bit seven");
  AST_BANKED: assert property (accept && mode_i == DG_M_DIR && acc_sel_i && l0.cls == DG_C_MEM
                               |=> mem_rd_o && mem_addr_o == $past({bank_sel_i, file_addr_i})) // RULE10
    else $error("banked address not formed from bank select");
  AST_IND_HOLD: assert property (accept && l0.cls == DG_C_VIRT && l0.sub == `DG_OFS_IND
                                 |=> ptr_o == $past(ptr_o))                // RULE15
    else $error("plain indirect access moved a pointer");
  AST_PRE_STEP: assert property (accept && l0.cls == DG_C_VIRT && l0.sub == `DG_OFS_INC_BEF
                               && l1.cls == DG_C_MEM && mode_i != DG_M_LIT
                               |=> mem_addr_o == $past(pv) + `DG_PTR_ONE)  // RULE16
    else $error("pre-increment did not address pointer plus one");
  AST_VOID: assert property (s_void_issue |=> s_no_access)                 // RULE19
    else $error("memory touched through a virtual operand");
endmodule // dg_core
`default_nettype wire

// [bench/dg_mem_model.sv]
// synchronous data memory behind the address unit
`timescale 1ns/10ps
`default_nettype none
module dg_mem_model (
  // clock
  input  wire logic        clk_i,
  // access
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] mem [4096];
  initial
  begin
    rdata_o = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // stale data inverted so a late sample never matches by luck
  always @(posedge clk_i)
  begin
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
    if (wr_i)
      mem[addr_i] <= wdata_i;
  end
endmodule // dg_mem_model
`default_nettype wire

// [bench/dg_core_test.sv]
// self-checking bench of the data address unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((e) !== (a)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module dg_core_test;
  import dg_pkg::*;
  logic clk_i, rst_i, step_i, acc_sel_i, dest_sel_i, ext_set_i, jump_i;
  logic wdt_timeout_i, wdt_clear_i, sleep_i, mem_rd_o, mem_wr_o, busy_o;
  logic wreg_we_o, pc_load_o;
  dg_op_t op_i;
  dg_mode_t mode_i;
  logic [7:0] file_addr_i, lit_i, wreg_i, mem_rdata_i, mem_wdata_o;
  logic [7:0] wreg_data_o, status_o;
  logic [11:0] src_full_i, dst_full_i, mem_addr_o;
  logic [3:0] bank_sel_i;
  logic [19:0] jump_target_i, pc_target_o;
  logic [2:0][11:0] ptr_o;
  int err_total = 0;
  int n_checks = 0;

  dg_core u_dg_core (.clk_i, .rst_i, .step_i, .op_i, .mode_i, .acc_sel_i, .dest_sel_i,
    .file_addr_i, .src_full_i, .dst_full_i, .lit_i, .bank_sel_i, .wreg_i, .ext_set_i,
    .jump_i, .jump_target_i, .wdt_timeout_i, .wdt_clear_i, .sleep_i, .mem_rdata_i,
    .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .busy_o, .wreg_we_o,
    .wreg_data_o, .status_o, .pc_load_o, .pc_target_o, .ptr_o);
  dg_mem_model u_dg_mem_model (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ************************************
  // instruction and event drivers
  // ************************************
  task automatic go(input dg_mode_t m, input dg_op_t o, input logic a, d,
                    input logic [7:0] f, input logic [11:0] ea, input logic r = 1'b1);
    @(negedge clk_i);
    mode_i = m;
    op_i = o;
    {acc_sel_i, dest_sel_i} = {a, d};
    file_addr_i = f;
    step_i = 1'b1;
    @(negedge clk_i);
    step_i = 1'b0;
    `CHK("issue", {1'b1, r, ea}, {busy_o, mem_rd_o, mem_addr_o})
    repeat (2) @(negedge clk_i);
  endtask

  task automatic lit(input dg_op_t o, input logic [7:0] k, w, input logic [8:0] ew);
    @(negedge clk_i);
    mode_i = DG_M_LIT;
    op_i = o;
    {lit_i, wreg_i} = {k, w};
    step_i = 1'b1;
    @(negedge clk_i);
    step_i = 1'b0;
    @(negedge clk_i);
    `CHK("w result", ew, {wreg_we_o, wreg_data_o})
    @(negedge clk_i);
  endtask

  task automatic ev(input logic [2:0] e, input logic [7:0] es);
    @(negedge clk_i);
    {wdt_timeout_i, wdt_clear_i, sleep_i} = e;
    @(negedge clk_i);
    {wdt_timeout_i, wdt_clear_i, sleep_i} = 3'h0;
    @(negedge clk_i);
    `CHK("status", es, status_o)
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_alu();
    lit(DG_ADD, 8'h01, 8'h7F, 9'h180);
    `CHK("status", 8'h7A, status_o)
    bank_sel_i = 4'h3;
    u_dg_mem_model.mem[12'h320] = 8'h80;
    u_dg_mem_model.mem[12'hF70] = 8'h01;
    go(DG_M_DIR, DG_RLC, 1'b1, 1'b1, 8'h20, 12'h320);
    `CHK("rlc wr", 21'h132000, {mem_wr_o, mem_addr_o, mem_wdata_o})
    `CHK("status", 8'h6F, status_o)
    go(DG_M_DIR, DG_RRC, 1'b0, 1'b0, 8'h70, 12'hF70);
    `CHK("rrc w", 9'h180, {wreg_we_o, wreg_data_o})
    `CHK("status", 8'h7B, status_o)
    lit(DG_SUB, 8'h05, 8'h05, 9'h100);
    `CHK("status", 8'h67, status_o)
    lit(DG_SUB, 8'h03, 8'h05, 9'h1FE);
    `CHK("status", 8'h70, status_o)
    wreg_i = 8'h85;
    go(DG_M_DIR, DG_XOR, 1'b0, 1'b1, 8'hD8, 12'hFD8, 1'b0);
    `CHK("status", 8'h70, status_o)
  endtask

  task automatic t_ptr();
    u_dg_mem_model.mem[12'h123] = 8'hF1;
    u_dg_mem_model.mem[12'h124] = 8'hFF;
    u_dg_mem_model.mem[12'h125] = 8'h40;
    u_dg_mem_model.mem[12'h126] = 8'h0F;
    u_dg_mem_model.mem[12'h127] = 8'hE7;
    u_dg_mem_model.mem[12'h128] = 8'hDA;
    {src_full_i, dst_full_i} = {12'h123, 12'hFEA};
    go(DG_M_FULL, DG_MOV, 1'b1, 1'b1, 8'h00, 12'h123);
    {src_full_i, dst_full_i} = {12'h124, 12'hFE9};
    go(DG_M_FULL, DG_MOV, 1'b1, 1'b1, 8'h00, 12'h124);
    `CHK("ptr0", 12'h1FF, ptr_o[0])
    {src_full_i, dst_full_i} = {12'h125, 12'hFD9};
    go(DG_M_FULL, DG_MOV, 1'b1, 1'b1, 8'h00, 12'h125);
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'hEE, 12'h1FF);
    `CHK("ptr0", 12'h200, ptr_o[0])
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'hEC, 12'h201);
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'hED, 12'h201);
    `CHK("ptr0", 12'h200, ptr_o[0])
    wreg_i = 8'hFF;
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'hEB, 12'h1FF);
    bank_sel_i = 4'hF;
    go(DG_M_DIR, DG_MOV, 1'b1, 1'b0, 8'hEF, 12'h200);
    `CHK("ptr0", 12'h200, ptr_o[0])
    `CHK("status", 8'h70, status_o)
    ext_set_i = 1'b1;
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'h10, 12'h050);
    ext_set_i = 1'b0;
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'h10, 12'h010);
    {src_full_i, dst_full_i} = {12'h126, 12'hFDA};
    go(DG_M_FULL, DG_MOV, 1'b1, 1'b1, 8'h00, 12'h126);
    {src_full_i, dst_full_i} = {12'h127, 12'hFD9};
    go(DG_M_FULL, DG_MOV, 1'b1, 1'b1, 8'h00, 12'h127);
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b0, 8'hDF, 12'hFE7, 1'b0);
    `CHK("void w", 9'h100, {wreg_we_o, wreg_data_o})
    {src_full_i, dst_full_i} = {12'h128, 12'hFD9};
    go(DG_M_FULL, DG_MOV, 1'b1, 1'b1, 8'h00, 12'h128);
    go(DG_M_DIR, DG_MOV, 1'b0, 1'b1, 8'hDD, 12'hFDA, 1'b0);
    `CHK("ptr2", 12'hFDA, ptr_o[2])
  endtask

  task automatic t_misc();
    ev(3'b100, 8'h30);
    ev(3'b010, 8'h70);
    ev(3'b001, 8'h50);
    @(negedge clk_i);
    jump_target_i = 20'hABCDE;
    jump_i = 1'b1;
    @(negedge clk_i);
    jump_i = 1'b0;
    `CHK("jump", 21'h1ABCDE, {pc_load_o, pc_target_o})
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("status", 8'h60, status_o)
  endtask

  initial
  begin
    {step_i, acc_sel_i, dest_sel_i, ext_set_i, jump_i} = 5'h00;
    {wdt_timeout_i, wdt_clear_i, sleep_i} = 3'h0;
    op_i = DG_NONE;
    mode_i = DG_M_INH;
    {file_addr_i, lit_i, wreg_i, bank_sel_i} = 28'h0000000;
    {src_full_i, dst_full_i, jump_target_i} = 44'h00000000000;
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("status", 8'h60, status_o)
    `CHK("ptrs", 36'h000000000, ptr_o)
    t_alu();
    t_ptr();
    t_misc();
    print_verdict();
  end

  // run needs well under 200 cycles
  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule // dg_core_test
`default_nettype wire
